//--- upec_map.vh
// constants for the packet check block: polynomial, reset values, field layout
// assumes inclusion by the design files of this block only
`ifndef UPEC_MAP_VH
`define UPEC_MAP_VH
`define UPEC_POLY_REFL   8'hb2
`define UPEC_CRC_INIT    8'h00
`define UPEC_ADDR_RST    5'h00
`define UPEC_BIT_LAST    3'h7
`define UPEC_ST1_PEC_BIT 0
`define UPEC_ST2_UP_BIT  0
`define UPEC_ST2_DN_BIT  1
`endif

//--- upec_fifo.v
// synchronous fifo for outgoing bytes, width and depth set by parameters
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module upec_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             clock,
    input  wire             reset,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    reg             in_ready_r;
    wire            wr_en;
    wire            rd_en;

    // registered not-full flag, so the ready output comes from a flop
    assign in_ready  = in_ready_r;
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rp_r];
    assign wr_en     = in_valid & in_ready;
    assign rd_en     = out_valid & out_ready;

    always @(posedge clock) begin
        if (wr_en) begin
            mem[wp_r] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            in_ready_r <= 1'b1;
        end else begin
            if (wr_en) begin
                wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (rd_en) begin
                rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (wr_en & ~rd_en) begin
                cnt_r      <= cnt_r + 1'b1;
                in_ready_r <= (cnt_r != DEPTH[AW:0] - 1'b1);
            end else if (rd_en & ~wr_en) begin
                cnt_r      <= cnt_r - 1'b1;
                in_ready_r <= 1'b1;
            end
        end
    end
endmodule // upec_fifo

//--- upec_check.v
// packet check byte engine: receive check of commands, transmit generation
// assumes bit strobes from the uart framer on the same clock; one clock domain
//
// Notes on behaviour
// - crc-8 engine with generator x^8+x^6+x^3+x^2+1, code 0xa6.
// - bytes enter the engine lsb first in link order.
// - remainder bit i is check byte bit i, both directions.
// - receive clears the engine, then feeds every command and data bit.
// - after last data bit remainder freezes, compared with trailing check byte.
// - mismatch rejects the command and sets the summary check error flag.
// - mismatch also sets the path error bit in the second status.
// - single-link setups always report on the up-path bit.
// - dual-link: up errors set up bit, down errors set down bit.
// - writes execute only when received check byte matches remainder.
// - transmit clears engine, feeds data lsb first, sends remainder lsb first.
// - read-all and single-device read carry a data-check byte.
// - after reset addresses read zero, speed and mode not detected.
// - check covers only bytes before it, not check byte or alive counter.
// - engine starts at zero per command; partial value may seed it.
// - reflected form: lsb one shifts right and xors 8'hb2.
`timescale 1ns/1ps
`include "upec_map.vh"
module upec_check #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    // clock and reset
    input  wire       clock,
    input  wire       reset,
    // configuration
    input  wire       dual_link,
    input  wire       rx_from_down,
    // receive bit stream
    input  wire       rx_start,
    input  wire       rx_bit_valid,
    input  wire       rx_bit,
    input  wire       rx_data_done,
    input  wire       rx_is_write,
    input  wire       rx_alive_bit,
    // receive verdict
    output reg        rx_done,
    output reg        rx_accept,
    output reg        write_exec,
    // status, sticky
    input  wire       clear_pec_errors,
    output reg        check_error_summary,
    output reg        up_path_check_error,
    output reg        down_path_check_error,
    // link state after reset
    input  wire       speed_detected_in,
    input  wire [4:0] addr_in,
    input  wire       addr_load,
    output reg  [4:0] device_addr,
    output reg        link_detected,
    // transmit byte stream
    input  wire       tx_start,
    input  wire       tx_byte_valid,
    output wire       tx_byte_ready,
    input  wire [7:0] tx_byte,
    input  wire       tx_last,
    input  wire       tx_seed_valid,
    input  wire [7:0] tx_seed,
    output reg        tx_bit_valid,
    output reg        tx_bit,
    output reg        tx_frame_end,
    input  wire       tx_bit_ready
);
    // one-hot receive states
    localparam RX_IDLE = 3'b001;
    localparam RX_DATA = 3'b010;
    localparam RX_PEC  = 3'b100;
    // one-hot transmit states
    localparam TX_IDLE = 3'b001;
    localparam TX_DATA = 3'b010;
    localparam TX_PEC  = 3'b100;

    // bit step of the reflected engine
    function [7:0] crc_step;
        input [7:0] crc;
        input       din;
        begin
            if (crc[0] ^ din) begin
                crc_step = (crc >> 1) ^ `UPEC_POLY_REFL;
            end else begin
                crc_step = crc >> 1;
            end
        end
    endfunction

    // pin inputs pass two flops
    reg [1:0] dual_sync_r;
    reg [1:0] det_sync_r;

    // receive side
    reg [2:0] rx_st_r;
    reg [7:0] rx_crc_r;
    reg [7:0] rx_pec_r;
    reg [2:0] rx_cnt_r;
    reg       rx_write_r;
    reg       rx_path_dn_r;
    wire      rx_mismatch;
    wire      err_up_set;
    wire      err_dn_set;

    always @(posedge clock) begin
        if (reset) begin
            dual_sync_r <= 2'b00;
            det_sync_r  <= 2'b00;
        end else begin
            dual_sync_r <= {dual_sync_r[0], dual_link};
            det_sync_r  <= {det_sync_r[0], speed_detected_in};
        end
    end

    assign rx_mismatch = (rx_pec_r != rx_crc_r);

    always @(posedge clock) begin
        if (reset) begin
            rx_st_r      <= RX_IDLE;
            rx_crc_r     <= `UPEC_CRC_INIT;
            rx_pec_r     <= 8'h00;
            rx_cnt_r     <= 3'h0;
            rx_write_r   <= 1'b0;
            rx_path_dn_r <= 1'b0;
            rx_done      <= 1'b0;
            rx_accept    <= 1'b0;
            write_exec   <= 1'b0;
        end else begin
            rx_done    <= 1'b0;
            rx_accept  <= 1'b0;
            write_exec <= 1'b0;
            if (rx_start) begin
                rx_st_r      <= RX_DATA;
                rx_crc_r     <= `UPEC_CRC_INIT;
                rx_cnt_r     <= 3'h0;
                rx_write_r   <= rx_is_write;
                rx_path_dn_r <= rx_from_down;
            end else begin
                case (rx_st_r)
                    RX_IDLE: begin
                        rx_st_r <= RX_IDLE;
                    end
                    RX_DATA: begin
                        // alive counter stays out of the check
                        if (rx_bit_valid && !rx_alive_bit) begin
                            rx_crc_r <= crc_step(rx_crc_r, rx_bit);
                        end
                        if (rx_data_done) begin
                            rx_st_r  <= RX_PEC;
                            rx_cnt_r <= 3'h0;
                        end
                    end
                    RX_PEC: begin
                        // remainder frozen; check byte shifts in lsb first
                        if (rx_bit_valid) begin
                            rx_pec_r <= {rx_bit, rx_pec_r[7:1]};
                            rx_cnt_r <= rx_cnt_r + 3'h1;
                            if (rx_cnt_r == `UPEC_BIT_LAST) begin
                                rx_st_r <= RX_IDLE;
                                rx_done <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        rx_st_r <= RX_IDLE;
                    end
                endcase
            end
            // verdict one cycle after last check bit lands
            if (rx_done) begin
                rx_accept  <= ~rx_mismatch;
                write_exec <= ~rx_mismatch & rx_write_r;
            end
        end
    end

    // path of a failing packet; single link always up
    assign err_up_set = rx_done & rx_mismatch &
                        (~dual_sync_r[1] | ~rx_path_dn_r);
    assign err_dn_set = rx_done & rx_mismatch &
                        dual_sync_r[1] & rx_path_dn_r;

    // set wins over a clear in the same cycle
    always @(posedge clock) begin
        if (reset) begin
            check_error_summary   <= 1'b0;
            up_path_check_error   <= 1'b0;
            down_path_check_error <= 1'b0;
        end else begin
            check_error_summary   <= (err_up_set | err_dn_set) |
                                     (check_error_summary & ~clear_pec_errors);
            up_path_check_error   <= err_up_set |
                                     (up_path_check_error & ~clear_pec_errors);
            down_path_check_error <= err_dn_set |
                                     (down_path_check_error & ~clear_pec_errors);
        end
    end

    // addresses and detection state after reset
    always @(posedge clock) begin
        if (reset) begin
            device_addr   <= `UPEC_ADDR_RST;
            link_detected <= 1'b0;
        end else begin
            if (addr_load) begin
                device_addr <= addr_in;
            end
            link_detected <= det_sync_r[1];
        end
    end

    // transmit: bytes buffered so the framer can stall the source
    wire       fq_valid;
    reg        fq_ready;
    wire [8:0] fq_data;

    upec_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (tx_byte_valid),
        .in_ready  (tx_byte_ready),
        .in_data   ({tx_last, tx_byte}),
        .out_valid (fq_valid),
        .out_ready (fq_ready),
        .out_data  (fq_data)
    );

    reg [2:0] tx_st_r;
    reg [7:0] tx_crc_r;
    reg [7:0] tx_sh_r;
    reg [2:0] tx_cnt_r;
    reg       tx_have_r;
    reg       tx_lastb_r;
    wire      tx_go;

    // a bit leaves when the framer can take one
    assign tx_go = ~tx_bit_valid | tx_bit_ready;

    always @* begin
        fq_ready = (tx_st_r == TX_DATA) && !tx_have_r;
    end

    always @(posedge clock) begin
        if (reset) begin
            tx_st_r      <= TX_IDLE;
            tx_crc_r     <= `UPEC_CRC_INIT;
            tx_sh_r      <= 8'h00;
            tx_cnt_r     <= 3'h0;
            tx_have_r    <= 1'b0;
            tx_lastb_r   <= 1'b0;
            tx_bit_valid <= 1'b0;
            tx_bit       <= 1'b0;
            tx_frame_end <= 1'b0;
        end else begin
            tx_frame_end <= 1'b0;
            if (tx_bit_valid && tx_bit_ready) begin
                tx_bit_valid <= 1'b0;
            end
            case (tx_st_r)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_st_r  <= TX_DATA;
                        // seed allows resuming a partial calculation
                        tx_crc_r <= tx_seed_valid ? tx_seed : `UPEC_CRC_INIT;
                    end
                end
                TX_DATA: begin
                    if (fq_valid && fq_ready) begin
                        tx_sh_r    <= fq_data[7:0];
                        tx_lastb_r <= fq_data[8];
                        tx_have_r  <= 1'b1;
                        tx_cnt_r   <= 3'h0;
                    end else if (tx_have_r && tx_go) begin
                        tx_bit_valid <= 1'b1;
                        tx_bit       <= tx_sh_r[0];
                        tx_crc_r     <= crc_step(tx_crc_r, tx_sh_r[0]);
                        tx_sh_r      <= tx_sh_r >> 1;
                        tx_cnt_r     <= tx_cnt_r + 3'h1;
                        if (tx_cnt_r == `UPEC_BIT_LAST) begin
                            tx_have_r <= 1'b0;
                            if (tx_lastb_r) begin
                                tx_st_r <= TX_PEC;
                            end
                        end
                    end
                end
                TX_PEC: begin
                    // remainder is shifted out lsb first as the check byte
                    if (tx_go) begin
                        tx_bit_valid <= 1'b1;
                        tx_bit       <= tx_crc_r[0];
                        tx_crc_r     <= tx_crc_r >> 1;
                        tx_cnt_r     <= tx_cnt_r + 3'h1;
                        if (tx_cnt_r == `UPEC_BIT_LAST) begin
                            tx_st_r      <= TX_IDLE;
                            tx_frame_end <= 1'b1;
                        end
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                end
            endcase
        end
    end
endmodule // upec_check

//--- upec_host_model.sv
// far-side model: takes device bits, checks them by zero remainder
// assumes the device clock and its synchronous active-high reset
`timescale 1ns/1ps
module upec_host_model (
    // clock and reset
    input  wire       clock,
    input  wire       reset,
    // frame control and back-pressure
    input  wire       start,
    input  wire       stall,
    // bit stream from the device
    input  wire       tx_bit_valid,
    input  wire       tx_bit,
    output wire       tx_bit_ready,
    // running remainder, bit count and last eight bits taken
    output reg  [7:0] rem_r,
    output reg  [7:0] count_r,
    output reg  [7:0] last_r
);
    // stalls come from the bench, so slow paths are exercised
    assign tx_bit_ready = !stall;
    always @(posedge clock) begin
        if (reset || start) begin
            rem_r   <= 8'h00;
            count_r <= 8'h00;
            last_r  <= 8'h00;
        end else if (tx_bit_valid && tx_bit_ready) begin
            // lsb first: after the frame this holds the check byte
            last_r  <= {tx_bit, last_r[7:1]};
            // check bits stay in the engine: zero means good
            rem_r   <= (rem_r[0] ^ tx_bit) ? (rem_r >> 1) ^ 8'hb2 : rem_r >> 1;
            count_r <= count_r + 8'h01;
        end
    end
endmodule // upec_host_model

//--- upec_check_assertions.sv
// checker for the packet check block, bound to its top module
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module upec_check_chk (
    // clock and reset
    input wire       clock,
    input wire       reset,
    // receive side
    input wire       dual_link,
    input wire       rx_done,
    input wire       rx_accept,
    input wire       write_exec,
    input wire       clear_pec_errors,
    input wire       check_error_summary,
    input wire       up_path_check_error,
    input wire       down_path_check_error,
    // link state
    input wire [4:0] addr_in,
    input wire       addr_load,
    input wire [4:0] device_addr,
    input wire       link_detected,
    // transmit side
    input wire       tx_bit_valid,
    input wire       tx_bit,
    input wire       tx_bit_ready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_acc; rx_accept |-> $past(rx_done); endproperty
    a_acc: assert property (p_acc) else $error("accept not after done");
    property p_wr; write_exec |-> rx_accept; endproperty
    a_wr: assert property (p_wr) else $error("write without accept");
    property p_rej;
        rx_accept |-> !$rose(up_path_check_error) && !$rose(down_path_check_error);
    endproperty
    a_rej: assert property (p_rej) else $error("accept with error");
    property p_path;
        $rose(up_path_check_error) || $rose(down_path_check_error) |-> check_error_summary;
    endproperty
    a_path: assert property (p_path) else $error("path error without summary");
    property p_down; $rose(down_path_check_error) |-> dual_link; endproperty
    a_down: assert property (p_down) else $error("down error in single link");
    property p_stick; check_error_summary && !clear_pec_errors |=> check_error_summary; endproperty
    a_stick: assert property (p_stick) else $error("summary dropped");
    property p_hold; tx_bit_valid && !tx_bit_ready |=> tx_bit_valid && $stable(tx_bit); endproperty
    a_hold: assert property (p_hold) else $error("tx bit not held");
    property p_rst; $fell(reset) |-> device_addr == 5'h00 && !link_detected; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_done; rx_done |=> !rx_done ##1 !rx_done; endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
endmodule // upec_check_chk
bind upec_check upec_check_chk u_chk (.clock, .reset, .dual_link, .rx_done, .rx_accept,
    .write_exec, .clear_pec_errors, .check_error_summary, .up_path_check_error,
    .down_path_check_error, .addr_in, .addr_load, .device_addr, .link_detected,
    .tx_bit_valid, .tx_bit, .tx_bit_ready);

//--- tb_top.sv
// self-checking bench for the packet check block
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t mismatch", $time); end end
module tb_top;
    reg        clock, reset, dual_link, rx_from_down, rx_start, rx_bit_valid, rx_bit;
    reg        rx_data_done, rx_is_write, rx_alive_bit, clear_pec_errors, speed_detected_in;
    reg        addr_load, tx_start, tx_byte_valid, tx_last, tx_seed_valid, stall, es, eu, ed;
    reg  [4:0] addr_in;
    reg  [7:0] tx_byte, tx_seed, txb, txc;
    reg [31:0] seed, r;
    wire       rx_done, rx_accept, write_exec, check_error_summary, up_path_check_error;
    wire       down_path_check_error, link_detected, tx_byte_ready, tx_bit_valid, tx_bit;
    wire       tx_frame_end, tx_bit_ready;
    wire [4:0] device_addr;
    wire [7:0] rem, cnt, last_chk;
    integer    mismatches, comparisons, j, k, cyc, ends;
    upec_check DUT (.clock, .reset, .dual_link, .rx_from_down, .rx_start, .rx_bit_valid,
        .rx_bit, .rx_data_done, .rx_is_write, .rx_alive_bit, .rx_done, .rx_accept,
        .write_exec, .clear_pec_errors, .check_error_summary, .up_path_check_error,
        .down_path_check_error, .speed_detected_in, .addr_in, .addr_load, .device_addr,
        .link_detected, .tx_start, .tx_byte_valid, .tx_byte_ready, .tx_byte, .tx_last,
        .tx_seed_valid, .tx_seed, .tx_bit_valid, .tx_bit, .tx_frame_end,
        .tx_bit_ready);
    upec_host_model host (.clock, .reset, .start(tx_start), .stall, .tx_bit_valid, .tx_bit,
        .tx_bit_ready, .rem_r(rem), .count_r(cnt), .last_r(last_chk));
    always #50 clock = ~clock;
    // fixed stall pattern keeps the far side slow on some bits
    always @(negedge clock) begin
        cyc++;
        stall <= cyc[0] & cyc[2];
        // frame end stands one cycle, so the falling edge sees it once
        if (tx_frame_end === 1'b1) ends++;
    end
    function [31:0] rnd();
        begin
            seed ^= seed << 13;
            seed ^= seed >> 17;
            seed ^= seed << 5;
            rnd = seed;
        end
    endfunction
    function [7:0] crcb(input [7:0] c, input [7:0] b);
        integer i;
        begin
            crcb = c ^ b;
            for (i = 0; i < 8; i++) crcb = crcb[0] ? (crcb >> 1) ^ 8'hb2 : crcb >> 1;
        end
    endfunction
    task rx_bits(input [7:0] b, input dd, input al);
        integer i;
        for (i = 0; i < 8; i++) begin
            @(negedge clock);
            {rx_bit_valid, rx_bit, rx_alive_bit, rx_data_done} = {1'b1, b[i], al, dd && i == 7};
            @(negedge clock);
            {rx_bit_valid, rx_alive_bit, rx_data_done} = 3'h0;
        end
    endtask
    task rxp(input int n, input wr, input dn, input bad);
        reg [7:0] c, d;
        integer i, w;
        begin
            c = 8'h00;
            @(negedge clock);
            {rx_start, rx_is_write, rx_from_down} = {1'b1, wr, dn};
            @(negedge clock);
            rx_start = 0;
            for (i = 0; i < n; i++) begin
                d = rnd();
                c = crcb(c, d);
                rx_bits(d, i == n - 1, 1'b0);
                if (i == 0 && n > 1) rx_bits(rnd(), 1'b0, 1'b1);
            end
            rx_bits(bad ? c ^ 8'h10 : c, 1'b0, 1'b0);
            w = 0;
            while (rx_done !== 1'b1 && w < 20) begin @(negedge clock); w++; end
            `CHK(rx_done, 1'b1)
            @(negedge clock);
            `CHK(rx_accept, !bad)
            `CHK(write_exec, wr && !bad)
            if (bad) begin es = 1; if (dual_link && dn) ed = 1; else eu = 1; end
            `CHK(check_error_summary, es)
            `CHK(up_path_check_error, eu)
            `CHK(down_path_check_error, ed)
        end
    endtask
    task push(input [7:0] b, input l);
        begin
            @(negedge clock);
            {tx_byte_valid, tx_byte, tx_last} = {1'b1, b, l};
            while (tx_byte_ready !== 1'b1) @(negedge clock);
            @(negedge clock);
            {tx_byte_valid, tx_last} = 2'h0;
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        {clock, dual_link, rx_from_down, rx_start, rx_bit_valid, rx_bit, rx_data_done} = 0;
        {rx_is_write, rx_alive_bit, clear_pec_errors, speed_detected_in, addr_load} = 0;
        {tx_start, tx_byte_valid, tx_last, stall, es, eu, ed, addr_in, tx_byte} = 0;
        {mismatches, comparisons, cyc, ends} = 0;
        {tx_seed_valid, tx_seed, txb, txc} = 0;
        reset = 1;
        seed = 48;
        repeat (6) @(posedge clock);
        @(negedge clock);
        reset = 0;
        `CHK(device_addr, 5'h00)
        `CHK(link_detected, 1'b0)
        r = rnd();
        {speed_detected_in, addr_load, addr_in} = {2'h3, r[4:0] | 5'h01};
        @(negedge clock);
        addr_load = 0;
        repeat (4) @(negedge clock);
        `CHK(device_addr, r[4:0] | 5'h01)
        `CHK(link_detected, 1'b1)
        $display("test reset done");
        rxp(1, 1, 0, 0);
        rxp(3, 1, 1, 1);
        dual_link = 1;
        repeat (4) @(negedge clock);
        rxp(2, 0, 1, 1);
        rxp(2, 1, 0, 0);
        @(negedge clock);
        clear_pec_errors = 1;
        @(negedge clock);
        {clear_pec_errors, es, eu, ed} = 0;
        rxp(4, 1, 0, 1);
        // a restart in mid-packet must drop what the engine holds
        @(negedge clock);
        rx_start = 1;
        @(negedge clock);
        rx_start = 0;
        r = rnd();
        rx_bits(r[7:0], 1'b0, 1'b0);
        rxp(2, 1, 0, 0);
        for (j = 0; j < 20; j++) begin
            r = rnd();
            rxp(1 + r[1:0], r[2], r[3], r[4] & r[5]);
        end
        $display("test rx done");
        // fill before the frame opens, so the full flag is seen
        txc = 8'h00;
        for (j = 0; j < 8; j++) begin
            txb = rnd();
            txc = crcb(txc, txb);
            push(txb, j == 7);
        end
        `CHK(tx_byte_ready, 1'b0)
        @(negedge clock);
        tx_start = 1;
        @(negedge clock);
        tx_start = 0;
        k = 0;
        while (cnt !== 8'h48 && k < 3000) begin @(negedge clock); k++; end
        repeat (4) @(negedge clock);
        `CHK(cnt, 8'h48)
        `CHK(rem, 8'h00)
        `CHK(last_chk, txc)
        `CHK(ends, 1)
        `CHK(tx_byte_ready, 1'b1)
        // resumed frame: the seed stands for a first byte sent earlier
        r = rnd();
        tx_seed = crcb(8'h00, r[7:0]);
        txc = tx_seed;
        for (j = 0; j < 3; j++) begin
            txb = rnd();
            txc = crcb(txc, txb);
            push(txb, j == 2);
        end
        @(negedge clock);
        {tx_start, tx_seed_valid} = 2'h3;
        @(negedge clock);
        {tx_start, tx_seed_valid} = 2'h0;
        k = 0;
        while (cnt !== 8'h20 && k < 3000) begin @(negedge clock); k++; end
        repeat (4) @(negedge clock);
        `CHK(cnt, 8'h20)
        `CHK(last_chk, txc)
        `CHK(ends, 2)
        $display("test tx done");
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("ERROR %0t watchdog", $time);
        end_sim;
    end
endmodule // tb_top
